// >>> inc/bsd_pkg.sv
// Shared types and constants of the burst sequence controller.
// Assumes one bus clock; all users import the whole package.
package bsd_pkg;

  // Widths of addresses, byte counts, tags and data.
  localparam int BSD_ADDR_W = 64;
  localparam int BSD_BC_W = 13;
  localparam int BSD_TAG_W = 5;
  localparam int BSD_NUM_TAGS = 32;
  localparam int BSD_LANES = 8;
  localparam int BSD_HALF_LANES = 4;
  localparam int BSD_DATA_W = 64;

  // Boundary geometry: 128-byte aligned stop boundary.
  localparam int BSD_BND_BYTES = 128;
  localparam logic [6:0] BSD_BND_LAST = 7'h7f;
  localparam int BSD_PHASES_64 = BSD_BND_BYTES / BSD_LANES;
  localparam int BSD_PHASES_32 = BSD_BND_BYTES / BSD_HALF_LANES;

  // Buffer sizing and the largest byte count of one sequence.
  localparam int BSD_MIN_BUF_BYTES = 128;
  localparam int BSD_BUF_WORDS = BSD_MIN_BUF_BYTES / BSD_LANES;
  localparam logic [12:0] BSD_MAX_BC = 13'h1000;

  // Way in which a transaction ended on the bus.
  typedef enum logic [2:0] {
    BSD_T_COUNT = 3'h0,
    BSD_T_BND = 3'h1,
    BSD_T_SDP = 3'h2,
    BSD_T_RETRY = 3'h3,
    BSD_T_TABORT = 3'h4,
    BSD_T_MABORT = 3'h5,
    BSD_T_SPLIT = 3'h6
  } bsd_term_t;

  // Controller states, Gray coded along idle, address, data, drain.
  typedef enum logic [1:0] {
    BSD_S_IDLE = 2'h0,
    BSD_S_ADDR = 2'h1,
    BSD_S_DATA = 2'h3,
    BSD_S_DRAIN = 2'h2
  } bsd_state_t;

  // One sequence request, also the address phase of a transaction.
  typedef struct packed {
    logic [BSD_ADDR_W-1:0] addr;
    logic [BSD_BC_W-1:0] bc;
    logic [BSD_TAG_W-1:0] tag;
    logic isWrite;
    logic wide;
  } bsd_req_t;

  // One word of data with byte enables, lanes by byte address.
  typedef struct packed {
    logic [BSD_DATA_W-1:0] data;
    logic [BSD_LANES-1:0] be;
  } bsd_beat_t;

  // One split completion seen by the requester.
  typedef struct packed {
    logic [BSD_TAG_W-1:0] tag;
    logic [BSD_ADDR_W-1:0] addr;
    logic [BSD_BC_W-1:0] bc;
    logic err;
  } bsd_cpl_t;

endpackage

// >>> hdl/bsd_fifo2.sv
// Small FIFO with valid and ready on both sides.
// Assumes the bus clock, active-low asynchronous reset and a clock enable.
`timescale 1ns/10ps
`default_nettype none

module bsd_fifo2 #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  // Clock, reset and enable.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Filling side.
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  // Draining side.
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } bsd_fifo_state_t;

  bsd_fifo_state_t r;
  bsd_fifo_state_t next_r;
  logic push;
  logic pull;

  ////////////////////////////////////////////////////////////////////////
  // Honest full and empty straight from the fill count.
  assign inReady = r.cnt != (PW + 1)'(DEPTH);
  assign outValid = r.cnt != '0;
  assign outData = r.mem[r.rp];
  assign push = inValid && inReady;
  assign pull = outValid && outReady;

  // Pointer wrap and count update.
  always_comb begin
    next_r = r;
    if (push) begin
      next_r.mem[r.wp] = inData;
      next_r.wp = (r.wp == PW'(DEPTH - 1)) ? '0 : r.wp + 1'b1;
    end
    if (pull) begin
      next_r.rp = (r.rp == PW'(DEPTH - 1)) ? '0 : r.rp + 1'b1;
    end
    if (push && !pull) begin
      next_r.cnt = r.cnt + 1'b1;
    end else if (pull && !push) begin
      next_r.cnt = r.cnt - 1'b1;
    end
  end

  // State register, frozen while the enable is low.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

endmodule

`default_nettype wire

// >>> hdl/bsd_requester.sv
// Requester side of a registered burst bus: runs read and write sequences,
// resumes disconnected writes, places bytes on lanes and tracks split tags.
// Assumes a bus engine that turns transactions and data phases into pins and
// reports how each transaction ended; everything runs on clk_sys.
`timescale 1ns/10ps
`default_nettype none

module bsd_requester (
  // Clock, reset and clock enable.
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic clkEn,
  // Sequence requests.
  input wire logic reqValid,
  output logic reqReady,
  input wire bsd_pkg::bsd_req_t req,
  input wire logic yieldAtBnd,
  // Write data stream, one aligned 8-byte word per beat.
  input wire logic wrValid,
  output logic wrReady,
  input wire bsd_pkg::bsd_beat_t wrBeat,
  // Sequence results.
  output logic doneValid,
  output logic [bsd_pkg::BSD_TAG_W-1:0] doneTag,
  output bsd_pkg::bsd_term_t doneCode,
  // Address phases toward the bus engine.
  output logic txnValid,
  input wire logic txnReady,
  output bsd_pkg::bsd_req_t txn,
  // Data phases toward the bus engine.
  output logic phValid,
  input wire logic phReady,
  output bsd_pkg::bsd_beat_t phBeat,
  output logic phLast,
  // Transaction end reported by the bus engine.
  input wire logic termValid,
  input wire bsd_pkg::bsd_term_t term,
  // Split completions addressed to this requester.
  input wire logic cplValid,
  input wire bsd_pkg::bsd_cpl_t cpl,
  output logic splitDoneValid,
  output logic [bsd_pkg::BSD_TAG_W-1:0] splitDoneTag,
  output logic splitDoneErr,
  output logic orderErr
);
  import bsd_pkg::*;

  typedef logic [BSD_BC_W-1:0] bsd_cnt_t;

  // Whole state of the controller.
  typedef struct packed {
    bsd_state_t st;
    bsd_req_t cur;
    logic sent;
    logic txnValid;
    logic phValid;
    bsd_beat_t ph;
    logic phLast;
    logic doneValid;
    logic [BSD_TAG_W-1:0] doneTag;
    bsd_term_t doneCode;
    logic [BSD_NUM_TAGS-1:0] open;
    logic [BSD_NUM_TAGS-1:0][BSD_BC_W-1:0] expAddr;
    logic [BSD_NUM_TAGS-1:0][BSD_BC_W-1:0] left;
    logic sdValid;
    logic [BSD_TAG_W-1:0] sdTag;
    logic sdErr;
    logic orderErr;
  } bsd_req_state_t;

  bsd_req_state_t r;
  bsd_req_state_t next_r;

  // Phase geometry of the current address.
  logic [3:0] wBytes;
  logic [3:0] off;
  logic [3:0] room;
  logic [3:0] nBytes;
  logic [6:0] endLow;
  logic atBnd;
  logic lastPh;
  logic popBeat;
  logic [BSD_LANES-1:0] laneMask;
  logic [BSD_DATA_W-1:0] srcData;
  logic [BSD_LANES-1:0] srcBe;

  // Buffer head and control.
  logic headValid;
  bsd_beat_t head;
  logic pop;
  logic canLoad;
  logic finish;
  logic [BSD_TAG_W-1:0] ct;

  ////////////////////////////////////////////////////////////////////////
  // Write data buffer; a full buffer drops wrReady back to the source.
  bsd_fifo2 #(
    .WIDTH($bits(bsd_beat_t)),
    .DEPTH(BSD_BUF_WORDS)
  ) u_buf (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .clkEn(clkEn),
    .inValid(wrValid),
    .inReady(wrReady),
    .inData(wrBeat),
    .outValid(headValid),
    .outReady(pop),
    .outData(head)
  );

  ////////////////////////////////////////////////////////////////////////
  // Width of a data phase and the bytes the next phase can carry.
  assign wBytes = r.cur.wide ? 4'(BSD_LANES) : 4'(BSD_HALF_LANES);
  assign off = r.cur.wide ? {1'b0, r.cur.addr[2:0]} : {2'h0, r.cur.addr[1:0]};
  assign room = wBytes - off;
  assign nBytes = (r.cur.bc < {9'h0, room}) ? r.cur.bc[3:0] : room;

  // A phase whose last byte has 7Fh in its low bits meets a boundary.
  assign endLow = r.cur.addr[6:0] + {3'h0, nBytes} - 7'h1;
  assign atBnd = endLow == BSD_BND_LAST;

  // Stop at the count, or at a boundary when asked to yield.
  assign lastPh = (r.cur.bc == {9'h0, nBytes}) || (yieldAtBnd && atBnd);

  // A narrow phase uses up a word after its upper half or at the end.
  assign popBeat = r.cur.wide || r.cur.addr[2] || (r.cur.bc == {9'h0, nBytes});

  // Upper half of a word shares the low lanes on a narrow transfer.
  always_comb begin
    if (r.cur.wide) begin
      srcData = head.data;
      srcBe = head.be;
    end else if (r.cur.addr[2]) begin
      srcData = {32'h0, head.data[63:32]};
      srcBe = {4'h0, head.be[7:4]};
    end else begin
      srcData = {32'h0, head.data[31:0]};
      srcBe = {4'h0, head.be[3:0]};
    end
  end

  // Only lanes between the current byte and the phase end are enabled.
  for (genvar i = 0; i < BSD_LANES; i++) begin : g_lane
    localparam logic [3:0] LI = 4'(i);
    assign laneMask[i] = (LI >= off) && (LI < off + nBytes) &&
                         (r.cur.wide || LI < 4'(BSD_HALF_LANES));
  end

  // A phase is staged while a write still has bytes and the buffer has data.
  assign canLoad = (r.st != BSD_S_IDLE) && r.cur.isWrite && !r.phValid &&
                   headValid && (r.cur.bc != '0);

  ////////////////////////////////////////////////////////////////////////
  // A tag may start only when neither the active nor a split sequence owns it.
  assign reqReady = (r.st == BSD_S_IDLE) && !r.open[req.tag] &&
                    (req.bc != '0) && (req.bc <= BSD_MAX_BC);

  // Outputs straight from the state.
  assign txnValid = r.txnValid;
  assign txn = r.cur;
  assign phValid = r.phValid && (r.st == BSD_S_DATA);
  assign phBeat = r.ph;
  assign phLast = r.phLast;
  assign doneValid = r.doneValid;
  assign doneTag = r.doneTag;
  assign doneCode = r.doneCode;
  assign splitDoneValid = r.sdValid;
  assign splitDoneTag = r.sdTag;
  assign splitDoneErr = r.sdErr;
  assign orderErr = r.orderErr;
  assign ct = cpl.tag;

  ////////////////////////////////////////////////////////////////////////
  // Next state of the sequence engine and the split tracker.
  always_comb begin
    next_r = r;
    next_r.doneValid = 1'b0;
    next_r.sdValid = 1'b0;
    next_r.sdErr = 1'b0;
    next_r.orderErr = 1'b0;
    pop = 1'b0;
    finish = 1'b0;

    // Take a new sequence and raise its first address phase.
    if (reqValid && reqReady) begin
      next_r.cur = req;
      next_r.sent = 1'b0;
      next_r.txnValid = 1'b1;
      next_r.st = BSD_S_ADDR;
    end

    // Address phase handed to the bus engine.
    if ((r.st == BSD_S_ADDR) && txnReady) begin
      next_r.txnValid = 1'b0;
      next_r.st = BSD_S_DATA;
    end

    // Stage the next data phase from the buffer head.
    if (canLoad) begin
      next_r.phValid = 1'b1;
      next_r.ph.data = srcData;
      next_r.ph.be = srcBe & laneMask;
      next_r.phLast = lastPh;
      pop = popBeat;
    end

    // Phase taken by the target, or thrown away while draining.
    if (r.phValid && (((r.st == BSD_S_DATA) && phReady) || (r.st == BSD_S_DRAIN))) begin
      next_r.phValid = 1'b0;
      next_r.cur.addr = r.cur.addr + {60'h0, nBytes};
      next_r.cur.bc = r.cur.bc - {9'h0, nBytes};
      if (r.st == BSD_S_DATA) begin
        next_r.sent = 1'b1;
      end else if (next_r.cur.bc == '0) begin
        next_r.st = BSD_S_IDLE;
      end
    end

    // End of a transaction decides between resume and end of sequence.
    if ((r.st == BSD_S_DATA) && termValid) begin
      next_r.st = BSD_S_IDLE;
      finish = 1'b1;
      case (term)
        BSD_T_BND, BSD_T_SDP: begin
          if (r.cur.isWrite && (next_r.cur.bc != '0)) begin
            next_r.st = BSD_S_ADDR;
            next_r.txnValid = 1'b1;
            finish = 1'b0;
          end
        end
        BSD_T_RETRY: begin
          if (r.cur.isWrite && next_r.sent) begin
            next_r.st = BSD_S_ADDR;
            next_r.txnValid = 1'b1;
            finish = 1'b0;
          end
        end
        BSD_T_SPLIT: begin
          finish = 1'b0;
          next_r.open[r.cur.tag] = 1'b1;
          next_r.expAddr[r.cur.tag] = next_r.cur.addr[BSD_BC_W-1:0];
          next_r.left[r.cur.tag] = r.cur.isWrite ? '0 : next_r.cur.bc;
        end
        default: begin
        end
      endcase
      // A read that ended keeps no state for a later retry.
      if (finish) begin
        next_r.doneValid = 1'b1;
        next_r.doneTag = r.cur.tag;
        next_r.doneCode = term;
      end
      // Leftover write words of an ended sequence are flushed from the buffer.
      if ((next_r.st == BSD_S_IDLE) && r.cur.isWrite && (next_r.cur.bc != '0)) begin
        next_r.st = BSD_S_DRAIN;
      end
    end

    // Split completions must arrive in ascending address order.
    if (cplValid && r.open[ct]) begin
      if (cpl.addr[BSD_BC_W-1:0] != r.expAddr[ct]) begin
        next_r.orderErr = 1'b1;
      end
      next_r.expAddr[ct] = r.expAddr[ct] + cpl.bc;
      next_r.left[ct] = r.left[ct] - cpl.bc;
      if (cpl.err || (cpl.bc >= r.left[ct])) begin
        next_r.open[ct] = 1'b0;
        next_r.left[ct] = '0;
        next_r.sdValid = 1'b1;
        next_r.sdTag = ct;
        next_r.sdErr = cpl.err;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // State register, frozen while the enable is low.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
    end else if (clkEn) begin
      r <= next_r;
    end
  end

endmodule

`default_nettype wire

// >>> tb/bsd_requester_props.sv
// Port assertions of the burst sequence requester.
// Assumes a bind onto bsd_requester, one clock and an active-low reset.
`timescale 1ns/10ps
`default_nettype none
module bsd_requester_props
  import bsd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Requests and results.
  input wire logic reqValid,
  input wire logic reqReady,
  input wire bsd_pkg::bsd_req_t req,
  input wire logic doneValid,
  input wire bsd_pkg::bsd_term_t doneCode,
  input wire logic splitDoneValid,
  // Bus engine side.
  input wire logic txnValid,
  input wire logic txnReady,
  input wire bsd_pkg::bsd_req_t txn,
  input wire logic phValid,
  input wire logic phReady,
  input wire bsd_pkg::bsd_beat_t phBeat,
  input wire logic termValid,
  input wire bsd_pkg::bsd_term_t term
);
  import bsd_pkg::*;
  logic curWide;
  ////////////////////////////////////////////////////////////////////////////
  // Width of the transaction whose data phases run.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      curWide <= 1'b0;
    end else if (txnValid && txnReady) begin
      curWide <= txn.wide;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // All checks share the bus clock and reset.
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  AST_REQ_LEGAL: assert property (reqValid && reqReady |->
    req.bc != 13'h0 && req.bc <= BSD_MAX_BC) else $error("request taken with bad count");
  AST_ONE_SEQ: assert property (txnValid |-> !reqReady)
    else $error("request ready during a transaction");
  AST_TXN_HOLD: assert property (txnValid && !txnReady |=> txnValid && $stable(txn))
    else $error("address phase changed before taken");
  AST_COUNT_DONE: assert property (termValid && term == BSD_T_COUNT |=>
    doneValid && doneCode == BSD_T_COUNT) else $error("count end not reported");
  AST_ABORT_DONE: assert property (termValid && term inside {BSD_T_TABORT, BSD_T_MABORT}
    |=> doneValid && doneCode == $past(term)) else $error("abort did not end sequence");
  AST_SPLIT_OPEN: assert property (termValid && term == BSD_T_SPLIT |=> !doneValid)
    else $error("split response ended sequence");
  AST_NARROW: assert property (phValid && !curWide |->
    phBeat.be[7:4] == 4'h0 && phBeat.data[63:32] == 32'h0) else $error("narrow lanes wrong");
  AST_PH_HOLD: assert property (phValid && !phReady && !termValid |=>
    phValid && $stable(phBeat)) else $error("data phase changed before taken");
  COV_STOP: cover property (termValid && term == BSD_T_BND);
  COV_SPLIT: cover property (splitDoneValid);
  COV_DONE: cover property (doneValid && doneCode == BSD_T_COUNT);
endmodule
`default_nettype wire

// >>> tb/bsd_tgt_model.sv
// Target side model: takes address and data phases and ends transactions.
// Assumes the bench sets forced endings and slow acceptance between sequences.
`timescale 1ns/10ps
`default_nettype none
module bsd_tgt_model
  import bsd_pkg::*;
(
  // Clock and reset.
  input wire logic clk_sys,
  input wire logic rst_n,
  // Bench controls.
  input wire logic forceOn,
  input wire bsd_pkg::bsd_term_t forceTerm,
  input wire logic slow,
  // Requester phases.
  input wire logic txnValid,
  output logic txnReady,
  input wire bsd_pkg::bsd_req_t txn,
  input wire logic phValid,
  output logic phReady,
  input wire bsd_pkg::bsd_beat_t phBeat,
  input wire logic phLast,
  // Transaction end.
  output logic termValid,
  output bsd_pkg::bsd_term_t term
);
  import bsd_pkg::*;
  logic act;
  logic fire;
  logic [12:0] need;
  logic [12:0] got;
  logic [12:0] nb;
  assign nb = got + 13'($countones(phBeat.be));
  // Takes each address phase a cycle late, then data or a forced ending.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      {txnReady, phReady, termValid, act, fire} <= 5'h0;
      {need, got} <= 26'h0;
      term <= BSD_T_COUNT;
    end else begin
      txnReady <= txnValid && !txnReady;
      termValid <= 1'b0;
      phReady <= act && !fire && (!slow || !phReady);
      if (txnValid && txnReady) begin
        {act, need, got} <= {1'b1, txn.bc, 13'h0};
        fire <= forceOn || !txn.isWrite;
      end else if (act && fire) begin
        termValid <= 1'b1;
        term <= forceTerm;
        {act, fire} <= 2'h0;
      end else if (phValid && phReady) begin
        got <= nb;
        if (phLast) begin
          termValid <= 1'b1;
          term <= (nb >= need) ? BSD_T_COUNT : BSD_T_BND;
          {act, phReady} <= 2'h0;
        end
      end
    end
  end
endmodule
`default_nettype wire

// >>> tb/tb_top.sv
// Bench for the burst sequence requester with a target model.
// Assumes bsd_pkg, the design and the model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
  import bsd_pkg::*;
  logic clk_sys, rst_n, clkEn, reqValid, yieldAtBnd, wrValid, cplValid, forceOn, slow;
  logic reqReady, wrReady, doneValid, txnValid, txnReady, phValid, phReady, phLast;
  logic termValid, splitDoneValid, splitDoneErr, orderErr, mWide, dSeen, sSeen, oSeen, sErr;
  logic [4:0] doneTag, splitDoneTag, dTag, sTag;
  logic [63:0] mAddr, la;
  logic [63:0] txAddr[$];
  logic [12:0] txBc[$];
  int phN[$];
  int totB;
  int err_total = 0;
  int cmp_count = 0;
  bsd_req_t req, txn;
  bsd_beat_t wrBeat, phBeat;
  bsd_term_t doneCode, term, forceTerm, dCode;
  bsd_cpl_t cpl;
  bsd_requester DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clkEn(clkEn), .reqValid(reqValid),
    .reqReady(reqReady), .req(req), .yieldAtBnd(yieldAtBnd), .wrValid(wrValid),
    .wrReady(wrReady), .wrBeat(wrBeat), .doneValid(doneValid), .doneTag(doneTag),
    .doneCode(doneCode), .txnValid(txnValid), .txnReady(txnReady), .txn(txn),
    .phValid(phValid), .phReady(phReady), .phBeat(phBeat), .phLast(phLast),
    .termValid(termValid), .term(term), .cplValid(cplValid), .cpl(cpl),
    .splitDoneValid(splitDoneValid), .splitDoneTag(splitDoneTag),
    .splitDoneErr(splitDoneErr), .orderErr(orderErr));
  bsd_tgt_model u_tgt (.clk_sys(clk_sys), .rst_n(rst_n), .forceOn(forceOn),
    .forceTerm(forceTerm), .slow(slow), .txnValid(txnValid), .txnReady(txnReady),
    .txn(txn), .phValid(phValid), .phReady(phReady), .phBeat(phBeat), .phLast(phLast),
    .termValid(termValid), .term(term));
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 4 ns.
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    if (err_total == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // Records phases and results; every taken byte must sit on its own lane.
  always @(posedge clk_sys) begin
    if (txnValid && txnReady) begin
      txAddr.push_back(txn.addr);
      txBc.push_back(txn.bc);
      phN.push_back(0);
      mAddr = txn.addr;
      mWide = txn.wide;
    end
    if (phValid && phReady) begin
      for (int l = 0; l < 8; l++) begin
        la = mWide ? {mAddr[63:3], 3'(l)} : {mAddr[63:2], 2'(l)};
        if (phBeat.be[l]) check(phBeat.data[8*l+:8], la[7:0]);
      end
      mAddr = mAddr + 64'($countones(phBeat.be));
      totB += $countones(phBeat.be);
      phN[phN.size()-1]++;
    end
    if (doneValid) {dSeen, dTag, dCode} = {1'b1, doneTag, doneCode};
    if (splitDoneValid) {sSeen, sTag, sErr} = {1'b1, splitDoneTag, splitDoneErr};
    if (orderErr) oSeen = 1'b1;
  end
  // Word of write data whose every byte holds its own low address bits.
  function automatic bsd_beat_t word(input logic [63:0] a);
    word.be = 8'hff;
    for (int n = 0; n < 8; n++)
      word.data[8*n+:8] = a[7:0] + 8'(n);
  endfunction
  task automatic pushWords(input logic [63:0] a, input int nw);
    int k;
    @(posedge clk_sys);
    for (int w = 0; w < nw; w++) begin
      wrValid <= 1'b1;
      wrBeat <= word(a + 64'(8 * w));
      k = 0;
      do begin
        @(posedge clk_sys);
        k++;
      end while (!wrReady && k < 500);
      if (k >= 500) begin
        err_total++;
        finish_test();
      end
    end
    wrValid <= 1'b0;
  endtask
  task automatic runSeq(input logic [63:0] a, input logic [12:0] bc, input logic [4:0] tg,
    input logic wr, input logic wd, input int nw);
    int k;
    {dSeen, sSeen, oSeen, totB} = 0;
    txAddr.delete();
    txBc.delete();
    phN.delete();
    @(posedge clk_sys);
    fork
      begin
        reqValid <= 1'b1;
        req <= '{a, bc, tg, wr, wd};
        k = 0;
        do begin
          @(posedge clk_sys);
          k++;
        end while (!reqReady && k < 100);
        if (k >= 100) begin
          err_total++;
          finish_test();
        end
        reqValid <= 1'b0;
      end
      pushWords({a[63:3], 3'h0}, nw);
    join
  endtask
  task automatic waitEnd();
    int k;
    for (k = 0; k < 2000 && !dSeen; k++) @(posedge clk_sys);
    if (!dSeen) begin
      err_total++;
      finish_test();
    end
    @(posedge clk_sys);
  endtask
  task automatic sendCpl(input logic [4:0] tg, input logic [63:0] a, input logic [12:0] bc,
    input logic e);
    @(posedge clk_sys);
    cplValid <= 1'b1;
    cpl <= '{tg, a, bc, e};
    @(posedge clk_sys);
    cplValid <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Scenarios.
  task automatic tWalk();
    runSeq(64'h7c, 13'h8, 5'h1, 1'b1, 1'b1, 2);
    waitEnd();
    check(txAddr.size(), 1);
    check(totB, 8);
    check({dCode, dTag}, {BSD_T_COUNT, 5'h1});
    runSeq(64'h7e, 13'h4, 5'h2, 1'b1, 1'b0, 2);
    waitEnd();
    check(phN[0], 2);
    check(totB, 4);
  endtask
  task automatic tBoundary();
    yieldAtBnd <= 1'b1;
    runSeq(64'h40, 13'h100, 5'h3, 1'b1, 1'b1, 32);
    waitEnd();
    check({txAddr[1], txBc[1]}, {64'h80, 13'hc0});
    check(txAddr[2], 64'h100);
    check(phN[1], 16);
    check(totB, 256);
    runSeq(64'h60, 13'ha0, 5'h3, 1'b1, 1'b0, 20);
    waitEnd();
    check(phN[1], 32);
    check((txAddr[1] - 64'h1) & 64'h7f, 64'h7f);
    yieldAtBnd <= 1'b0;
  endtask
  task automatic tEnds();
    bsd_term_t wc[3] = '{BSD_T_RETRY, BSD_T_TABORT, BSD_T_MABORT};
    bsd_term_t rc[5] = '{BSD_T_COUNT, BSD_T_SDP, BSD_T_RETRY, BSD_T_TABORT, BSD_T_MABORT};
    forceOn <= 1'b1;
    foreach (wc[i]) begin
      forceTerm <= wc[i];
      runSeq(64'h200, 13'h10, 5'h4, 1'b1, 1'b1, 2);
      waitEnd();
      check({dCode, 32'(txAddr.size())}, {wc[i], 32'h1});
    end
    forceOn <= 1'b0;
    foreach (rc[i]) begin
      forceTerm <= rc[i];
      runSeq(64'h300, 13'h40, 5'h6, 1'b0, 1'b1, 0);
      waitEnd();
      check(dCode, rc[i]);
    end
  endtask
  task automatic tSplit();
    forceTerm <= BSD_T_SPLIT;
    runSeq(64'h400, 13'h40, 5'h7, 1'b0, 1'b1, 0);
    repeat (10) @(posedge clk_sys);
    check(dSeen, 0);
    #1 check(reqReady, 0);
    @(posedge clk_sys) req.tag <= 5'h8;
    #1 check(reqReady, 1);
    sendCpl(5'h9, 64'h400, 13'h40, 1'b0);
    check(sSeen, 0);
    sendCpl(5'h7, 64'h400, 13'h20, 1'b0);
    check({oSeen, sSeen}, 2'b00);
    sendCpl(5'h7, 64'h400, 13'h20, 1'b0);
    check({oSeen, sSeen, sTag}, {2'b11, 5'h7});
    @(posedge clk_sys) req.tag <= 5'h7;
    #1 check(reqReady, 1);
    runSeq(64'h400, 13'h40, 5'ha, 1'b0, 1'b1, 0);
    // Let the split response open the tag before its completion arrives.
    repeat (10) @(posedge clk_sys);
    sendCpl(5'ha, 64'h400, 13'h0, 1'b1);
    check({sSeen, sErr, sTag}, {2'b11, 5'ha});
  endtask
  task automatic tFull();
    slow <= 1'b1;
    pushWords(64'h0, 16);
    #1 check(wrReady, 0);
    runSeq(64'h0, 13'h80, 5'h2, 1'b1, 1'b1, 0);
    waitEnd();
    check(totB, 128);
    slow <= 1'b0;
  endtask
  // Reset for 20 cycles, then the scenarios.
  initial begin
    {rst_n, reqValid, yieldAtBnd, wrValid, cplValid, forceOn, slow} = 7'h0;
    clkEn = 1'b1;
    {req, wrBeat, cpl} = '0;
    forceTerm = BSD_T_COUNT;
    repeat (20) @(posedge clk_sys);
    rst_n <= 1'b1;
    tWalk();
    tBoundary();
    tEnds();
    tSplit();
    tFull();
    finish_test();
  end
endmodule
bind bsd_requester bsd_requester_props u_props (.clk_sys(clk_sys), .rst_n(rst_n),
  .reqValid(reqValid), .reqReady(reqReady), .req(req), .doneValid(doneValid),
  .doneCode(doneCode), .splitDoneValid(splitDoneValid), .txnValid(txnValid),
  .txnReady(txnReady), .txn(txn), .phValid(phValid), .phReady(phReady),
  .phBeat(phBeat), .termValid(termValid), .term(term));
`default_nettype wire
